// ### pcid_config_id_command.sv
// identity words and command word of the configuration header
// assumes config requests, boot memory reader, decoder and parity logic
// all run on ref_clk_in, so their signals need no synchroniser
`timescale 1ns/100ps
`include "pcid_consts.svh"
`default_nettype none

module pcid_config_id_command #(
  parameter logic [15:0] VENDOR_DEFAULT = 16'h5a5a, // arbitrary value
  parameter logic [15:0] DEVICE_DEFAULT = 16'ha5a5, // arbitrary value
  parameter int          NV_AW          = 9
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             cfg_valid_in,
  input  wire logic             cfg_write_in,
  input  wire logic [7:0]       cfg_addr_in,
  input  wire logic [3:0]       cfg_byte_en_in,
  input  wire logic [31:0]      cfg_wdata_in,
  output logic                  cfg_ready_out,
  output logic                  cfg_ack_out,
  output logic [31:0]           cfg_rdata_out,
  input  wire logic             nv_present_in,
  input  wire logic             nv_contents_ok_in,
  output logic                  nv_rd_req_out,
  output logic [NV_AW-1:0]      nv_rd_addr_out,
  input  wire logic             nv_rd_ack_in,
  input  wire logic [7:0]       nv_rd_data_in,
  output logic                  io_space_en_out,
  output logic                  mem_space_en_out,
  output logic                  bus_master_en_out,
  output logic                  parity_check_en_out,
  output logic                  system_error_gate_out,
  input  wire logic             serr_event_in,
  input  wire logic             parity_error_in,
  input  wire logic             master_want_in,
  input  wire logic             mem_hit_in,
  input  wire logic             io_hit_in,
  output logic                  serr_n_out,
  output logic                  serr_oe_out,
  output logic                  perr_n_out,
  output logic                  perr_oe_out,
  output logic                  bus_request_out,
  output logic                  target_claim_out
);

  generate
    if (NV_AW < 7) begin : g_bad_aw
      $error("boot memory address too narrow for identity bytes");
    end
  endgenerate

  localparam pcid_pkg::pcid_state_t ST_RST = '{
    ld:    pcid_pkg::LD_CHECK,
    nb:    2'h0,
    ids:   {DEVICE_DEFAULT, VENDOR_DEFAULT},
    cmd:   `PCID_CMD_RESET,
    rdata: 32'h0000_0000,
    ack:   1'b0,
    nvreq: 1'b0,
    serr:  1'b0,
    perr:  1'b0,
    req:   1'b0,
    claim: 1'b0
  };

  pcid_pkg::pcid_state_t st;
  pcid_pkg::pcid_state_t next_st;

  logic taken;
  logic wr_taken;

  // true when a byte address falls in the same dword as a register offset
  function automatic logic same_dw(input logic [7:0] a,
                                   input logic [7:0] ofs);
    same_dw = (a[7:2] == ofs[7:2]);
  endfunction

  // replace one byte lane of a 32-bit word
  function automatic logic [31:0] put_byte(input logic [31:0] w,
                                           input logic [1:0]  i,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = w;
    r[{i, 3'h0} +: 8] = b;
    put_byte = r;
  endfunction

  // merge written bytes of the low half word under the lane enables
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8],
               be[0] ? wd[7:0]  : old[7:0]};
  endfunction

  // requests wait while identities load so software never sees a
  // half-loaded identity
  assign cfg_ready_out = (st.ld == pcid_pkg::LD_DONE);
  assign taken         = cfg_valid_in && cfg_ready_out;
  assign wr_taken      = taken && cfg_write_in;

  always_comb begin
    next_st       = st;
    next_st.ack   = 1'b0;
    next_st.nvreq = 1'b0;
    case (st.ld)
      pcid_pkg::LD_CHECK: begin
        if (nv_present_in && nv_contents_ok_in) begin
          next_st.ld = pcid_pkg::LD_ISSUE; // see R2
          next_st.nb = 2'h0;
        end else begin
          next_st.ld = pcid_pkg::LD_DONE;
        end
      end
      pcid_pkg::LD_ISSUE: begin
        next_st.nvreq = 1'b1;
        next_st.ld    = pcid_pkg::LD_WAIT;
      end
      pcid_pkg::LD_WAIT: begin
        next_st.nvreq = 1'b1;
        if (nv_rd_ack_in) begin
          // lanes 0-1 vendor, 2-3 device
          next_st.ids   = put_byte(st.ids, st.nb,
                                   nv_rd_data_in); // see R2 see R4
          next_st.nvreq = 1'b0;
          if (st.nb == `PCID_NV_LAST) begin
            next_st.ld = pcid_pkg::LD_DONE;
          end else begin
            next_st.nb = st.nb + 2'h1;
            next_st.ld = pcid_pkg::LD_ISSUE;
          end
        end
      end
      pcid_pkg::LD_DONE: begin
        next_st.ld = pcid_pkg::LD_DONE;
      end
      default: begin
        next_st.ld = pcid_pkg::LD_DONE;
      end
    endcase

    if (taken) begin
      next_st.ack = 1'b1;
      if (cfg_write_in) begin
        // identity dword has no write path at all
        if (same_dw(cfg_addr_in, `PCID_OFS_CMD)) begin
          // unwritable and reserved bits stay zero
          next_st.cmd = merge16(st.cmd, cfg_wdata_in[15:0], // see R11
                                cfg_byte_en_in[1:0]) // see R12 see R13
                        & `PCID_CMD_WR_MASK; // see R5 see R6 see R9
        end
        next_st.rdata = 32'h0000_0000;
      end else if (same_dw(cfg_addr_in, `PCID_OFS_VENDOR)) begin
        next_st.rdata = st.ids; // see R3 see R1
      end else if (same_dw(cfg_addr_in, `PCID_OFS_CMD)) begin
        // status half lives elsewhere and reads zero here
        next_st.rdata = {16'h0000, st.cmd}; // see R6
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end

    // gated requests toward the pins and engines, one cycle late
    next_st.serr  = serr_event_in
                    && st.cmd[`PCID_BIT_SERR]; // see R8
    next_st.perr  = parity_error_in
                    && st.cmd[`PCID_BIT_PARITY]; // see R10
    next_st.req   = master_want_in
                    && st.cmd[`PCID_BIT_MASTER]; // see R14
    next_st.claim = (mem_hit_in && st.cmd[`PCID_BIT_MEM])
                    || (io_hit_in && st.cmd[`PCID_BIT_IO]); // see R17
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st <= ST_RST; // see R5 see R7
    end else begin
      st <= next_st;
    end
  end

  assign cfg_ack_out    = st.ack;
  assign cfg_rdata_out  = st.rdata;
  assign nv_rd_req_out  = st.nvreq;
  assign nv_rd_addr_out = NV_AW'(`PCID_NV_ID_BASE) + NV_AW'(st.nb);

  assign io_space_en_out       = st.cmd[`PCID_BIT_IO]; // see R16
  assign mem_space_en_out      = st.cmd[`PCID_BIT_MEM]; // see R15
  assign bus_master_en_out     = st.cmd[`PCID_BIT_MASTER];
  assign parity_check_en_out   = st.cmd[`PCID_BIT_PARITY];
  assign system_error_gate_out = st.cmd[`PCID_BIT_SERR];

  // open-drain style pins only ever pull low; the enable carries the event
  // no fast back-to-back path exists, the stored bit only reads back
  assign serr_n_out       = 1'b0;
  assign serr_oe_out      = st.serr;
  assign perr_n_out       = 1'b0;
  assign perr_oe_out      = st.perr;
  assign bus_request_out  = st.req;
  assign target_claim_out = st.claim;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  id_write_ro_a: assert property ( // see R1
    wr_taken && same_dw(cfg_addr_in, `PCID_OFS_DEVICE)
    |=> $stable(st.ids)
  ) else $error("identity words changed on a config write");

  cmd_reset_zero_a: assert property ( // see R5
    $rose(rst_n_in) |-> (st.cmd == `PCID_CMD_RESET)
  ) else $error("command word not zero after reset");

  cmd_fixed_bits_a: assert property ( // see R6
    ##1 ((st.cmd & ~`PCID_CMD_WR_MASK) == 16'h0000)
  ) else $error("reserved or hardwired command bit set");

  cmd_write_a: assert property ( // see R5
    wr_taken && same_dw(cfg_addr_in, `PCID_OFS_CMD)
    && (cfg_byte_en_in[1:0] == 2'h3)
    |=> cfg_ack_out
        && (st.cmd == ($past(cfg_wdata_in[15:0]) & `PCID_CMD_WR_MASK))
  ) else $error("command write not stored or not acked");

  serr_gate_a: assert property ( // see R8
    serr_oe_out |-> $past(st.cmd[`PCID_BIT_SERR])
                    && $past(serr_event_in)
  ) else $error("system error driven while gated off");

  perr_gate_a: assert property ( // see R10
    ##1 (perr_oe_out == ($past(parity_error_in)
                         && $past(st.cmd[`PCID_BIT_PARITY])))
  ) else $error("parity error pin wrong for enable");

  master_gate_a: assert property ( // see R14
    bus_request_out |-> $past(st.cmd[`PCID_BIT_MASTER])
  ) else $error("bus requested while master disabled");

  claim_gate_a: assert property ( // see R17
    !st.cmd[`PCID_BIT_MEM] && !st.cmd[`PCID_BIT_IO]
    ##1 !st.cmd[`PCID_BIT_MEM] && !st.cmd[`PCID_BIT_IO]
    |-> !target_claim_out
  ) else $error("cycle claimed with both spaces disabled");

  nv_device_load_a: assert property ( // see R2
    (st.ld == pcid_pkg::LD_WAIT) && nv_rd_ack_in && (st.nb == 2'h2)
    |=> (st.ids[23:16] == $past(nv_rd_data_in)) ##[1:2] 1'b1
  ) else $error("device identity byte not loaded");

  nv_absent_a: assert property ( // see R4
    (st.ld == pcid_pkg::LD_CHECK) && !nv_present_in
    |=> cfg_ready_out && $stable(st.ids) && !nv_rd_req_out
  ) else $error("load ran without boot memory");

  ready_bound_a: assert property ( // see R2
    $rose(rst_n_in) && !nv_present_in |-> ##1 cfg_ready_out
  ) else $error("config not ready after skipped load");

  // back-to-back requests keep ack high, so ack must track taken exactly
  ack_timing_a: assert property ( // see R3
    ##1 (cfg_ack_out == $past(taken))
  ) else $error("config ack not one cycle after request");

  nv_req_hold_a: assert property ( // see R2
    nv_rd_req_out && !nv_rd_ack_in
    |=> nv_rd_req_out && $stable(nv_rd_addr_out)
  ) else $error("boot memory request dropped before ack");

  nv_vendor_load_a: assert property ( // see R4
    (st.ld == pcid_pkg::LD_WAIT) && nv_rd_ack_in && (st.nb == 2'h0)
    |=> (st.ids[7:0] == $past(nv_rd_data_in))
  ) else $error("vendor identity byte not loaded");

  nv_invalid_a: assert property ( // see R2
    (st.ld == pcid_pkg::LD_CHECK) && !nv_contents_ok_in
    |=> cfg_ready_out && !nv_rd_req_out
  ) else $error("load ran on invalid boot memory");

  load_blocks_a: assert property ( // see R1
    (st.ld != pcid_pkg::LD_DONE) |=> !cfg_ack_out
  ) else $error("config request taken during identity load");

  write_rdata_a: assert property ( // see R1
    wr_taken |=> cfg_ack_out && (cfg_rdata_out == 32'h0000_0000)
  ) else $error("write answered with nonzero data");

  cmd_read_a: assert property ( // see R6
    taken && !cfg_write_in && same_dw(cfg_addr_in, `PCID_OFS_CMD)
    |=> ((cfg_rdata_out & 32'hffff_fc00) == 32'h0000_0000)
  ) else $error("reserved command bits read nonzero");

  mem_claim_a: assert property ( // see R15
    mem_hit_in && st.cmd[`PCID_BIT_MEM] |=> target_claim_out
  ) else $error("enabled memory hit not claimed");

  io_claim_a: assert property ( // see R16
    io_hit_in && st.cmd[`PCID_BIT_IO] |=> target_claim_out
  ) else $error("enabled I/O hit not claimed");

  serr_drive_a: assert property ( // see R8
    serr_event_in && st.cmd[`PCID_BIT_SERR] |=> serr_oe_out
  ) else $error("enabled system error not driven");

endmodule

`default_nettype wire

// ### pcid_consts.svh
// constants for the configuration identity and command block
// assumes byte offsets within the configuration header, 8-bit wide
// How it works
// R1: device identity word is read only; configuration writes leave it alone
// R2: after reset, device identity loads from boot memory bytes 042h-043h if valid
// R3: vendor identity word presents one 16-bit number in bits 15:0
// R4: vendor identity loads from boot memory bytes 040h-041h; writes never alter it
// R5: command word resets to 0000h; six writable fields; others read zero
// R6: command bits 15:10 always read zero
// R7: fast back-to-back bit clears at reset; device never does such transfers
// R8: bit 8 gates the open-drain system error output
// R9: wait cycle bit 7 is hardwired zero; no stepping
// R10: bit 6 enables parity checking; only then is the parity error pin driven
// R11: palette snoop bit 5 is hardwired zero
// R12: write-and-invalidate bit 4 is hardwired zero
// R13: special cycle bit 3 is hardwired zero
// R14: bit 2 must be set before the device requests the bus
// R15: bit 1 must be set before memory cycles are claimed
// R16: bit 0 must be set before I/O cycles are claimed
// R17: a disabled space is never claimed, so such cycles master abort
`ifndef PCID_CONSTS_SVH
`define PCID_CONSTS_SVH
`define PCID_OFS_VENDOR  8'h00
`define PCID_OFS_DEVICE  8'h02
`define PCID_OFS_CMD     8'h04
`define PCID_CMD_RESET   16'h0000
`define PCID_CMD_WR_MASK 16'h0347
`define PCID_BIT_IO      0
`define PCID_BIT_MEM     1
`define PCID_BIT_MASTER  2
`define PCID_BIT_PARITY  6
`define PCID_BIT_SERR    8
`define PCID_BIT_FBB     9
`define PCID_NV_ID_BASE  11'h040
`define PCID_NV_LAST     2'h3
`endif

// ### pcid_nv_model.sv
// boot memory model: answers byte reads of the identity words
// assumes the reader holds req and addr until the ack edge
`timescale 1ns/100ps
`default_nettype none
module pcid_nv_model #(
  parameter int AW = 9
) (
  input  wire logic          ref_clk_in,
  input  wire logic          slow_in,
  input  wire logic          req_in,
  input  wire logic [AW-1:0] addr_in,
  output logic               ack_out,
  output logic [7:0]         data_out
);
  // bytes 040h..043h: vendor 1234, device abcd
  logic [7:0] mem [4] = '{8'h34, 8'h12, 8'hcd, 8'hab};
  int         cnt     = 0;
  initial ack_out = 1'b0;
  initial data_out = 8'h00;
  // data toggles outside the ack cycle so a stale byte never looks valid
  always @(posedge ref_clk_in) begin
    ack_out <= 1'b0;
    data_out <= ~data_out;
    cnt <= req_in ? cnt + 1 : 0;
    if (req_in && !ack_out && cnt >= (slow_in ? 3 : 0)) begin
      ack_out <= 1'b1;
      // a reader pointed outside the identity bytes gets a poisoned byte
      data_out <= ({addr_in[AW-1:2], 2'b00} == AW'(11'h040))
                  ? mem[addr_in[1:0]] : 8'hee;
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// ### pcid_pkg.sv
// types for the configuration identity and command block
// assumes nothing beyond the constants header
package pcid_pkg;

  typedef enum logic [3:0] {
    LD_CHECK = 4'b0001,
    LD_ISSUE = 4'b0010,
    LD_WAIT  = 4'b0100,
    LD_DONE  = 4'b1000
  } pcid_load_t;

  typedef struct packed {
    pcid_load_t  ld;
    logic [1:0]  nb;
    logic [31:0] ids;
    logic [15:0] cmd;
    logic [31:0] rdata;
    logic        ack;
    logic        nvreq;
    logic        serr;
    logic        perr;
    logic        req;
    logic        claim;
  } pcid_state_t;

endpackage

// ### tb_top.sv
// self-checking bench for the identity and command block
// assumes the boot memory model is compiled before this file
`timescale 1ns/100ps
`include "pcid_consts.svh"
`default_nettype none
module tb_top;
  localparam logic [31:0] DEF  = 32'h3c3cc3c3; // arbitrary identity
  localparam logic [31:0] NVID = 32'habcd1234; // matches the model
  logic        clk, rst_n, valid, wr, pres, ok, slow;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic [31:0] wdata, r, id;
  logic [4:0]  ev;
  logic [15:0] cm, wm;
  wire         ready, ack, nreq, nack, serr_n, perr_n;
  wire [31:0]  rdata;
  wire [8:0]   naddr;
  wire [7:0]   ndata;
  wire [4:0]   en;
  wire [3:0]   pin;
  logic [31:0] exp_q[$];
  int          failures   = 0;
  int          n_compared = 0;
  int          cyc        = 0;

  pcid_config_id_command #(.VENDOR_DEFAULT(DEF[15:0]),
    .DEVICE_DEFAULT(DEF[31:16])) pcid_config_id_command_inst (
    .ref_clk_in(clk), .rst_n_in(rst_n), .cfg_valid_in(valid),
    .cfg_write_in(wr), .cfg_addr_in(addr), .cfg_byte_en_in(be),
    .cfg_wdata_in(wdata), .cfg_ready_out(ready), .cfg_ack_out(ack),
    .cfg_rdata_out(rdata), .nv_present_in(pres), .nv_contents_ok_in(ok),
    .nv_rd_req_out(nreq), .nv_rd_addr_out(naddr), .nv_rd_ack_in(nack),
    .nv_rd_data_in(ndata), .io_space_en_out(en[0]),
    .mem_space_en_out(en[1]), .bus_master_en_out(en[2]),
    .parity_check_en_out(en[3]), .system_error_gate_out(en[4]),
    .serr_event_in(ev[0]), .parity_error_in(ev[1]),
    .master_want_in(ev[2]), .mem_hit_in(ev[3]), .io_hit_in(ev[4]),
    .serr_n_out(serr_n), .serr_oe_out(pin[0]), .perr_n_out(perr_n),
    .perr_oe_out(pin[1]), .bus_request_out(pin[2]),
    .target_claim_out(pin[3]));
  pcid_nv_model pcid_nv_model_inst (.ref_clk_in(clk), .slow_in(slow),
    .req_in(nreq), .addr_in(naddr), .ack_out(nack), .data_out(ndata));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // request stays up until ready was seen before a rising edge
  task automatic cfg(input logic w, input logic [7:0] a,
                     input logic [3:0] b, input logic [31:0] d,
                     input logic [31:0] e);
    exp_q.push_back(e);
    {valid, wr, addr, be, wdata} <= {1'b1, w, a, b, d};
    while (ready !== 1'b1) @(negedge clk);
    @(negedge clk);
  endtask

  task automatic boot(input logic p, input logic k, input logic s);
    {rst_n, valid, pres, ok, slow} <= {1'b0, 1'b0, p, k, s};
    repeat (4) @(negedge clk);
    rst_n <= 1'b1;
    cm = 16'h0;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      $display("ERROR %0t: timeout", $time);
      end_sim();
    end
  end

  // every ack retires the oldest expected answer
  always @(negedge clk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0)
        cmp(32'h1, 32'h0);
      else
        cmp(rdata, exp_q.pop_front());
    end
  end

  initial begin
    {rst_n, valid, wr, pres, ok, slow, addr, be, wdata} = '0;
    ev = 5'h00;
    r = 32'h1cdeb1c4;
    @(negedge clk);
    for (int i = 0; i < 5; i++) begin
      boot(i[1] | i[2], i[0] | i[2], i[2]);
      id = (i > 2) ? NVID : DEF;
      @(negedge clk);
      cmp(32'({ack, en, pin}), 32'h0);
      cfg(1'b0, 8'h00, 4'hf, 32'h0, id);
      r = lfsr(r);
      cfg(1'b1, 8'h00, 4'hf, r, 32'h0);
      cfg(1'b0, 8'h02, 4'hf, 32'h0, id);
      cfg(1'b0, 8'h04, 4'hf, 32'h0, 32'h0);
      for (int j = 0; j < 16; j++) begin
        r = lfsr(r);
        wm = {{8{r[17]}}, {8{r[16]}}} & `PCID_CMD_WR_MASK;
        cm = (cm & ~wm) | (r[15:0] & 16'hfdff & wm);
        cfg(1'b1, 8'h04, r[19:16], r & 32'hfffffdff, 32'h0);
        cfg(1'b0, 8'h04, 4'hf, 32'h0, {16'h0, cm});
        ev <= r[24:20];
        valid <= 1'b0;
        @(negedge clk);
        cmp(32'(en), 32'({cm[8], cm[6], cm[2:0]}));
        cmp(32'({pin, serr_n, perr_n}), 32'({ev[4] & cm[0] | ev[3] & cm[1],
          ev[2] & cm[2], ev[1] & cm[6], ev[0] & cm[8], 2'b00}));
      end
      cfg(1'b1, 8'h08, 4'hf, r, 32'h0);
      cfg(1'b0, 8'h08, 4'hf, 32'h0, 32'h0);
      cfg(1'b0, 8'h04, 4'hf, 32'h0, {16'h0, cm});
      valid <= 1'b0;
      @(negedge clk);
      $display("test %0d done", i);
    end
    @(negedge clk);
    end_sim();
  end
endmodule
`default_nettype wire
